// ### rtl/smp_port.sv
// Serial programming port: memory arrays, lock and fuse bits, self-timed writes.
// Assumes the link clock stands still or low while the reset pin is high.
`timescale 1ns/1ps
// How it works
// R01 - EEPROM write erases the byte itself
// R02 - Chip erase sets both arrays to ones
// R03 - Separate program and EEPROM address spaces
// R04 - Serial clock phases exceed two system cycles
// R05 - Sample rising, shift out falling
// R06 - Programmer holds reset and clock low
// R07 - Programmer waits 20 ms before enable; the bench waits 12 clk_sys cycles
// R08 - Enable instruction accepted only under reset
// R09 - Echo second enable byte during third
// R10 - Programmer retries enable up to 32
// R11 - Chip erase, wait, pulse reset, restart
// R12 - Write program byte, high or low
// R13 - Read program byte in fourth byte
// R14 - Write EEPROM byte at third byte
// R15 - Read EEPROM byte in fourth byte
// R16 - Write lock bits, zero programs
// R17 - Read lock bits in bits 2,1
// R18 - Signature read, refused in lock mode 3
// R19 - Write fuses, zero programs, one unprograms
// R20 - Read fuses from bit 5 down
// R21 - EEPROM polling returns 00, FF, value
// R22 - Program polling returns FF then value
// R23 - Programmer waits erase delay
// R24 - Programmer waits write delay unless polling
// R25 - Raising reset leaves programming mode
module smp_port
#(
   parameter int PROG_AW        = smp_pkg::PROG_AW,
   parameter int EE_AW          = smp_pkg::EE_AW,
   parameter int PROG_WRITE_CYC = smp_pkg::PROG_WRITE_CYC,
   parameter int EE_ERASE_CYC   = smp_pkg::EE_ERASE_CYC,
   parameter int CHIP_ERASE_CYC = smp_pkg::CHIP_ERASE_CYC,
   parameter logic [7:0] SIG0   = 8'h3C, // Arbitrary identity value
   parameter logic [7:0] SIG1   = 8'h55, // Arbitrary identity value
   parameter logic [7:0] SIG2   = 8'hAA  // Arbitrary identity value
)
(
   input  wire logic       clk_sys,
   input  wire logic       resetn,
   input  wire logic       resetPin,
   input  wire logic       sck,
   input  wire logic       mosi,
   output logic            miso,
   output logic            progMode,
   output logic            busy,
   output logic [1:0]      lockBits,
   output logic [4:0]      fuseBits
);
   localparam int PW = PROG_AW + 1;
   localparam int PD = 1 << PW;
   localparam int ED = 1 << EE_AW;

   // Link held in reset while the reset pin is high
   wire linkResetn = resetn & ~resetPin; // [R25]

   logic [31:0] frame;
   logic        frameToggle;
   logic        enabled;
   logic [7:0]  readByte;

   smp_link u_link
   (
      .sck         (sck),
      .linkResetn  (linkResetn),
      .mosi        (mosi),
      .miso        (miso),
      .frame       (frame),
      .frameToggle (frameToggle),
      .enabled     (enabled),
      .readByte    (readByte),
      .echoByte    (smp_pkg::OP_ENABLE_B2)
   );

   // Crossing of the frame event and mode level into clk_sys
   logic [2:0] togSync;
   logic [1:0] enSync;
   logic [1:0] rstSync;
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         togSync <= 3'b000;
         enSync  <= 2'b00;
         rstSync <= 2'b11;
      end
      else
      begin
         togSync <= {togSync[1:0], frameToggle};
         enSync  <= {enSync[0], enabled};
         rstSync <= {rstSync[0], resetPin};
      end
   end
   // One pulse per received frame
   wire frameEvt = togSync[2] ^ togSync[1];

   // Mode from flops; drops a few cycles after the reset pin rises
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         progMode <= 1'b0;
      else
         progMode <= enSync[1] & ~rstSync[1];
   end

   // Program accesses carry the byte select in the opcode; other opcodes are exact
   function automatic logic [7:0] opKey(input logic [7:0] opIn);
      logic [7:0] masked;
      masked = opIn & smp_pkg::OP_H_MASK;
      if (masked == smp_pkg::OP_RD_PROG || masked == smp_pkg::OP_WR_PROG)
         return masked;
      return opIn;
   endfunction

   // Frame stays stable between toggles, so fields may be read after the crossing
   wire [7:0] op      = frame[31:24];
   wire [7:0] b2      = frame[23:16];
   wire [7:0] b3      = frame[15:8];
   wire [7:0] b4      = frame[7:0];
   wire       hSel    = op[smp_pkg::HBIT_POS];
   wire [7:0] opNoH   = opKey(op);
   wire [PW-1:0] pAddr = {b2[PROG_AW-9:0], b3, hSel}; // [R03]
   wire [EE_AW-1:0] eAddr = b3[EE_AW-1:0]; // [R03]
   wire isGrp   = (op == smp_pkg::OP_ENABLE_GRP);
   wire isErase = isGrp && (b2[7:5] == smp_pkg::OP_ERASE_B2);
   wire isLock  = isGrp && (b2[7:3] == smp_pkg::OP_LOCK_B2);
   wire isFuse  = isGrp && (b2[7:5] == smp_pkg::OP_FUSE_B2);
   wire isWProg = (opNoH == smp_pkg::OP_WR_PROG);
   wire isWEe   = (op == smp_pkg::OP_WR_EE);

   logic [7:0] progMem [PD];
   logic [7:0] eeMem   [ED];

   smp_pkg::smp_state_t state;
   smp_pkg::smp_state_t next_state;
   logic [31:0]     timer;
   logic            wrIsEe;
   logic [PW-1:0]   wrPAddr;
   logic [EE_AW-1:0] wrEAddr;
   logic [7:0]      wrData;

   wire startErase = frameEvt && isErase && state == smp_pkg::SMP_IDLE;
   wire startWrite = frameEvt && (isWProg || isWEe) && state == smp_pkg::SMP_IDLE;
   wire timerDone  = (timer == 32'h0000_0000);
   wire eeErasing  = wrIsEe && (timer >= 32'(PROG_WRITE_CYC));

   // Self-timed operation: idle, chip erase or one byte write
   always_comb
   begin
      next_state = state;
      case (state)
         smp_pkg::SMP_IDLE:
            if (startErase)
               next_state = smp_pkg::SMP_ERASE;
            else if (startWrite)
               next_state = smp_pkg::SMP_WRITE;
         smp_pkg::SMP_ERASE,
         smp_pkg::SMP_WRITE:
            if (timerDone)
               next_state = smp_pkg::SMP_IDLE;
         default:
            next_state = smp_pkg::SMP_IDLE;
      endcase
   end

   // Timer loads on start and counts down to zero; EEPROM write includes its erase
   wire [31:0] eeWriteCyc   = 32'(EE_ERASE_CYC + PROG_WRITE_CYC - 1); // [R01]
   wire [31:0] progWriteCyc = 32'(PROG_WRITE_CYC - 1);
   wire [31:0] eraseCyc     = 32'(CHIP_ERASE_CYC - 1);
   wire [31:0] next_timer   = startErase ? eraseCyc :
                              startWrite ? (isWEe ? eeWriteCyc : progWriteCyc) :
                              timerDone  ? timer : timer - 32'h0000_0001;
   wire        eraseDone    = (state == smp_pkg::SMP_ERASE) && timerDone;
   wire        writeDone    = (state == smp_pkg::SMP_WRITE) && timerDone;

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state <= smp_pkg::SMP_IDLE;
         timer <= 32'h0000_0000;
      end
      else
      begin
         state <= next_state;
         timer <= next_timer;
      end
   end

   // Address and data held for the whole self-timed write
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         wrIsEe  <= 1'b0;
         wrPAddr <= '0;
         wrEAddr <= '0;
         wrData  <= 8'h00;
      end
      else if (startWrite)
      begin
         wrIsEe  <= isWEe;
         wrPAddr <= pAddr;
         wrEAddr <= eAddr;
         wrData  <= b4;
      end
   end

   // Lock bits return to unprogrammed only through chip erase or resetn
   wire       lockWrite     = frameEvt && isLock;
   wire       fuseWrite     = frameEvt && isFuse;
   wire [1:0] next_lockBits = eraseDone ? smp_pkg::LOCK_RESET :
                              lockWrite ? (lockBits & b2[2:1]) : lockBits; // [R16]
   wire [4:0] next_fuseBits = fuseWrite ? b2[4:0] : fuseBits; // [R19]

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         lockBits <= smp_pkg::LOCK_RESET;
         fuseBits <= smp_pkg::FUSE_RESET;
      end
      else
      begin
         lockBits <= next_lockBits;
         fuseBits <= next_fuseBits;
      end
   end

   // Arrays without reset, written at the end of the self-timed operation
   always_ff @(posedge clk_sys)
   begin
      if (eraseDone)
      begin
         for (int i = 0; i < PD; i++)
            progMem[i] <= smp_pkg::ERASED_VALUE; // [R02]
         for (int i = 0; i < ED; i++)
            eeMem[i] <= smp_pkg::ERASED_VALUE; // [R02]
      end
      else if (writeDone)
      begin
         if (wrIsEe)
            eeMem[wrEAddr] <= wrData; // [R14]
         else
            progMem[wrPAddr] <= wrData; // [R12]
      end
   end

   assign busy = (state != smp_pkg::SMP_IDLE);

   // Read decode from a local copy of the first three link bytes
   // Link clock half period is long; value settles before the fourth byte is loaded
   logic [23:0] hdrLive;
   always_ff @(posedge sck or negedge linkResetn) // [R05]
   begin
      if (!linkResetn)
         hdrLive <= 24'h00_0000;
      else
         hdrLive <= {hdrLive[22:0], mosi};
   end

   wire [7:0]  rOp     = hdrLive[23:16];
   wire [7:0]  rdOp    = opKey(rOp);
   wire [7:0]  rB3     = hdrLive[7:0];
   wire [PW-1:0] rPAddr = {hdrLive[PROG_AW-1:8], rB3, rOp[smp_pkg::HBIT_POS]};
   wire [EE_AW-1:0] rEAddr = rB3[EE_AW-1:0];
   // Polling compares the live header address with the byte being written
   wire writing  = (state == smp_pkg::SMP_WRITE);
   wire pPolled  = writing && !wrIsEe && (wrPAddr == rPAddr);
   wire ePolled  = writing && wrIsEe && (wrEAddr == rEAddr);
   wire lockMode3 = (lockBits == 2'b00);

   // Identity byte by index; the unused fourth index reads zero
   function automatic logic [7:0] sigSelect(input logic [1:0] idx);
      case (idx)
         2'h0:    return SIG0;
         2'h1:    return SIG1;
         2'h2:    return SIG2;
         default: return smp_pkg::READ_ZERO;
      endcase
   endfunction

   wire [7:0] sigByte = sigSelect(rB3[1:0]);
   wire [7:0] progRd = pPolled ? smp_pkg::ERASED_VALUE : progMem[rPAddr]; // [R22]
   wire [7:0] eeRd   = !ePolled ? eeMem[rEAddr] :
                       eeErasing ? smp_pkg::EEPROM_POLL_ERASING_VAL : // [R21]
                       smp_pkg::EEPROM_POLL_ERASED_VAL;
   wire [7:0] fuseRd = {2'b00, smp_pkg::SERIAL_PROG_ENABLE_FUSE_FUSE_VAL, fuseBits}; // [R20]

   always_comb
   begin
      case (rdOp)
         smp_pkg::OP_RD_PROG: readByte = progRd; // [R13]
         smp_pkg::OP_RD_EE:   readByte = eeRd; // [R15]
         smp_pkg::OP_RD_LOCK: readByte = {5'b00000, lockBits, 1'b0}; // [R17]
         smp_pkg::OP_RD_SIG:  readByte = lockMode3 ? smp_pkg::READ_ZERO : sigByte; // [R18]
         smp_pkg::OP_RD_FUSE: readByte = fuseRd;
         default:             readByte = smp_pkg::READ_ZERO;
      endcase
   end
endmodule

// ### common/smp_pkg.sv
// Constants for the serial memory programming port.
// Assumes a 250 MHz system clock and an SPI-style link clocked by the programmer.
package smp_pkg;
   // Instruction opcodes (first byte, or second-byte fields for the B2 names; H bit masked where it applies)
   localparam logic [7:0] OP_ENABLE_GRP  = 8'hAC;
   localparam logic [7:0] OP_ENABLE_B2   = 8'h53;
   localparam logic [2:0] OP_ERASE_B2    = 3'h4;
   localparam logic [4:0] OP_LOCK_B2     = 5'h1F;
   localparam logic [2:0] OP_FUSE_B2     = 3'h5;
   localparam logic [7:0] OP_RD_PROG     = 8'h20;
   localparam logic [7:0] OP_WR_PROG     = 8'h40;
   localparam logic [7:0] OP_RD_EE       = 8'hA0;
   localparam logic [7:0] OP_WR_EE       = 8'hC0;
   localparam logic [7:0] OP_RD_LOCK     = 8'h58;
   localparam logic [7:0] OP_RD_SIG      = 8'h30;
   localparam logic [7:0] OP_RD_FUSE     = 8'h50;
   localparam logic [7:0] OP_H_MASK      = 8'hF7;
   localparam int         HBIT_POS       = 3;
   // Fixed values
   localparam logic [7:0] ERASED_VALUE            = 8'hFF;
   localparam logic [7:0] EEPROM_POLL_ERASING_VAL = 8'h00;
   localparam logic [7:0] EEPROM_POLL_ERASED_VAL  = 8'hFF;
   localparam logic [7:0] READ_ZERO               = 8'h00;
   localparam logic [1:0] LOCK_RESET              = 2'h3;
   localparam logic [4:0] FUSE_RESET              = 5'h1F;
   localparam logic       SERIAL_PROG_ENABLE_FUSE_FUSE_VAL          = 1'b0;
   // Address widths for the larger variant
   localparam int PROG_AW = 11;
   localparam int EE_AW   = 8;
   // Self-timed write and erase times in microseconds
   localparam int CLK_MHZ        = 250;
   localparam int PROG_WRITE_US  = 4000;
   localparam int EE_ERASE_US    = 2000;
   localparam int CHIP_ERASE_US  = 8000;
   localparam int PROG_WRITE_CYC = PROG_WRITE_US * CLK_MHZ;
   localparam int EE_ERASE_CYC   = EE_ERASE_US * CLK_MHZ;
   localparam int CHIP_ERASE_CYC = CHIP_ERASE_US * CLK_MHZ;
   // Command kinds; not used by the port or the link
   typedef enum logic [2:0] {
      SMP_CMD_NONE  = 3'h0,
      SMP_CMD_ERASE = 3'h1,
      SMP_CMD_WPROG = 3'h2,
      SMP_CMD_WEE   = 3'h3,
      SMP_CMD_LOCK  = 3'h4,
      SMP_CMD_FUSE  = 3'h5
   } smp_cmd_t;
   typedef enum logic [1:0] {
      SMP_IDLE  = 2'b00,
      SMP_ERASE = 2'b10,
      SMP_WRITE = 2'b01
   } smp_state_t;
endpackage

// ### rtl/smp_link.sv
// Link side of the programming port: shifter and instruction framing.
// Runs on the programmer's serial clock; held in reset while the device reset pin is high.
`timescale 1ns/1ps
module smp_link
(
   input  wire logic       sck,
   input  wire logic       linkResetn,
   input  wire logic       mosi,
   output logic            miso,
   output logic [31:0]     frame,
   output logic            frameToggle,
   output logic            enabled,
   input  wire logic [7:0] readByte,
   input  wire logic [7:0] echoByte
);
   logic [4:0]  bitCount;
   logic [30:0] shiftIn;
   logic [7:0]  shiftOut;
   logic        sampled;
   wire  [31:0] fullWord    = {shiftIn, mosi};
   wire         byteEnd     = (bitCount[2:0] == 3'h7);
   wire         isEnableCmd = (fullWord[31:24] == smp_pkg::OP_ENABLE_GRP)
                              && (fullWord[23:16] == smp_pkg::OP_ENABLE_B2);

   // Input sampled on rising edge
   always_ff @(posedge sck or negedge linkResetn) // [R05]
   begin
      if (!linkResetn)
      begin
         bitCount    <= 5'h00; // [R25]
         shiftIn     <= '0;
         frame       <= '0;
         frameToggle <= 1'b0;
         enabled     <= 1'b0;
         sampled     <= 1'b0;
      end
      else
      begin
         bitCount <= bitCount + 5'h01;
         shiftIn  <= fullWord[30:0];
         sampled  <= byteEnd;
         if (bitCount == 5'h1F)
         begin
            if (isEnableCmd)
               enabled <= 1'b1; // [R08]
            if (enabled)
            begin
               frame       <= fullWord;
               frameToggle <= ~frameToggle;
            end
         end
      end
   end

   // Output shifted on falling edge; byte loaded after the second and third byte boundaries
   always_ff @(negedge sck or negedge linkResetn) // [R05]
   begin
      if (!linkResetn)
         shiftOut <= 8'h00;
      else if (sampled && bitCount == 5'h10)
         shiftOut <= {echoByte[6:0], 1'b0}; // [R09]
      else if (sampled && bitCount == 5'h18)
         shiftOut <= {readByte[6:0], 1'b0};
      else
         shiftOut <= {shiftOut[6:0], 1'b0};
   end

   logic firstBit;
   always_ff @(negedge sck or negedge linkResetn)
   begin
      if (!linkResetn)
         firstBit <= 1'b0;
      else if (sampled && bitCount == 5'h10)
         firstBit <= echoByte[7];
      else if (sampled && bitCount == 5'h18)
         firstBit <= readByte[7];
      else
         firstBit <= shiftOut[7];
   end
   assign miso = firstBit;
endmodule

// ### verification/smp_port_checker.sv
// Concurrent checks on the programming port pins.
// Assumes the self-timed counts match those given to the port.
`timescale 1ns/1ps
module smp_port_checker
#(
   parameter int PROG_WRITE_CYC = 1,
   parameter int EE_ERASE_CYC   = 1,
   parameter int CHIP_ERASE_CYC = 1
)
(
   input wire logic       clk_sys,
   input wire logic       resetn,
   input wire logic       resetPin,
   input wire logic       sck,
   input wire logic       miso,
   input wire logic       progMode,
   input wire logic       busy,
   input wire logic [1:0] lockBits,
   input wire logic [4:0] fuseBits
);
   localparam int BUSY_MAX = PROG_WRITE_CYC + EE_ERASE_CYC + CHIP_ERASE_CYC + 16;
   int busyCnt;
   always_ff @(posedge clk_sys or negedge resetn)
      if (!resetn) busyCnt <= 0;
      else busyCnt <= busy ? busyCnt + 1 : 0;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   a_mode_needs_pin: assert property ($rose(progMode) |-> !resetPin)
      else $error("mode entered with reset pin high");
   a_busy_needs_mode: assert property ($rose(busy) |-> progMode)
      else $error("write started outside mode");
   a_pin_leaves_mode: assert property (resetPin [*6] |-> !progMode)
      else $error("mode kept with reset pin high");
   a_mode_holds: assert property (progMode && !resetPin && !$past(resetPin, 8) |=> progMode)
      else $error("mode lost with reset pin low");
   a_busy_min: assert property ($rose(busy) |-> busy [*8])
      else $error("self-timed write too short");
   a_busy_bound: assert property (busyCnt <= BUSY_MAX)
      else $error("self-timed write never ends");
   a_lock_quiet: assert property (!progMode && !busy |=> $stable(lockBits))
      else $error("lock bits moved outside mode");
   a_fuse_quiet: assert property (!progMode && !busy |=> $stable(fuseBits))
      else $error("fuse bits moved outside mode");
   a_miso_falling: assert property ($changed(miso) |-> !sck)
      else $error("serial out moved while link clock high");
   a_reset_values: assert property ($rose(resetn) |-> lockBits == 2'h3 && fuseBits == 5'h1F)
      else $error("wrong lock or fuse reset value");
   c_mode: cover property ($rose(progMode));
   c_write_done: cover property ($fell(busy));
   c_lock_mode3: cover property (lockBits == 2'h0);
endmodule
bind smp_port smp_port_checker #(.PROG_WRITE_CYC(PROG_WRITE_CYC), .EE_ERASE_CYC(EE_ERASE_CYC),
   .CHIP_ERASE_CYC(CHIP_ERASE_CYC)) chk (.clk_sys(clk_sys), .resetn(resetn),
   .resetPin(resetPin), .sck(sck), .miso(miso), .progMode(progMode), .busy(busy),
   .lockBits(lockBits), .fuseBits(fuseBits));

// ### verification/smp_prog_model.sv
// Programmer model: drives link clock and serial data, samples the reply.
// Assumes the device shifts its reply out on falling link edges.
`timescale 1ns/1ps
module smp_prog_model
(
   output logic      sck,
   output logic      mosi,
   input  wire logic miso
);
   initial
   begin
      sck = 1'b0;
      mosi = 1'b0;
   end
   // Always all four bytes, 40 ns phases
   task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
      #1.7;
      for (int i = 31; i >= 0; i--)
      begin
         mosi = tx[i];
         #40 sck = 1'b1;
         rx[i] = miso;
         #40 sck = 1'b0;
      end
      mosi = ~tx[0];
   endtask
   task automatic pulse();
      #40 sck = 1'b1;
      #40 sck = 1'b0;
   endtask
endmodule

// ### verification/serial_memory_programming_port_tb.sv
// Bench: programmer model, reference memories and port checks.
// Assumes the self-timed counts shortened below.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_fail++; \
   $display("mismatch %s exp %h got %h", nm, e, s); end end
module serial_memory_programming_port_tb;
   logic        clk_sys, resetn, resetPin, sck, mosi, miso, progMode, busy;
   logic [1:0]  lockBits;
   logic [4:0]  fuseBits;
   logic [31:0] r, seed;
   logic [7:0]  eeM [int], pgM [int], sig [3];
   int          n_fail, checks_done, c;
   smp_prog_model p (.sck(sck), .mosi(mosi), .miso(miso));
   // Identity values arbitrary; the third keeps its default
   smp_port #(.PROG_WRITE_CYC(1500), .EE_ERASE_CYC(1500), .CHIP_ERASE_CYC(2000),
      .SIG0(8'h12), .SIG1(8'h34)) dut (.clk_sys(clk_sys), .resetn(resetn),
      .resetPin(resetPin), .sck(sck), .mosi(mosi), .miso(miso), .progMode(progMode),
      .busy(busy), .lockBits(lockBits), .fuseBits(fuseBits));
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic finish_test();
      if (n_fail == 0 && checks_done > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic pin(input logic v);
      @(posedge clk_sys) resetPin <= v;
      tick(12);
   endtask
   task automatic ins(input logic [31:0] tx);
      p.xfer(tx, r);
   endtask
   task automatic idle();
      for (int k = 0; k < 4000 && busy !== 1'b0; k++) @(posedge clk_sys);
      tick(2);
   endtask
   task automatic enter();
      for (int k = 0; k < 32; k++)
      begin
         ins(32'hAC530000);
         if (r[15:8] === 8'h53) break;
         p.pulse();
      end
      `CHK("echo", 8'h53, r[15:8])
   endtask
   task automatic wr(input logic [7:0] wop, rop, input logic [10:0] a, input logic [7:0] d, p1);
      int ph;
      ph = 0;
      ins({wop, 5'h0, a, d});
      `CHK("busy", 1'b1, busy)
      for (int k = 0; k < 12; k++)
      begin
         ins({rop, 5'h0, a, 8'h00});
         c = r[7:0] === p1 ? 0 : r[7:0] === 8'hFF ? 1 : r[7:0] === d ? 2 : 3;
         if (k == 0) `CHK("first", p1, r[7:0])
         `CHK("order", 1'b1, c >= ph && c < 3)
         ph = c;
         if (c == 2) break;
      end
      `CHK("data", d, r[7:0])
      idle();
   endtask
   initial
   begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end
   initial
   begin
      #300000;
      n_fail++;
      finish_test();
   end
   initial
   begin
      logic [31:0] v;
      resetn = 1'b0;
      resetPin = 1'b1;
      seed = 32'h0000239A;
      sig = '{8'h12, 8'h34, 8'hAA};
      tick(4);
      @(posedge clk_sys) resetn <= 1'b1;
      tick(2);
      `CHK("lock", 2'h3, lockBits)
      `CHK("fuse", 5'h1F, fuseBits)
      ins(32'hAC530000);
      tick(8);
      `CHK("mode", 1'b0, progMode)
      // Reset pulse ends with the link clock low; power-up wait scaled down
      pin(1'b0);
      enter();
      tick(8);
      `CHK("mode", 1'b1, progMode)
      ins(32'hAC800000);
      idle();
      pin(1'b1);
      pin(1'b0);
      enter();
      for (int i = 0; i < 4; i++)
      begin
         v = rnd();
         ins({16'hA000, v[7:0], 8'h00});
         `CHK("ee_erased", 8'hFF, r[7:0])
         ins({4'h2, v[11], 3'h0, 5'h0, v[10:0], 8'h00});
         `CHK("pg_erased", 8'hFF, r[7:0])
      end
      for (int i = 0; i < 6; i++)
      begin
         v = rnd();
         if (v[7:0] == 8'h00 || v[7:0] == 8'hFF) v[7:0] = 8'h5A;
         if (i == 1 || i == 2) v[15:8] = 8'hFF;
         if (i > 3) v[19:8] = {i == 5, 11'h7FF};
         if (i < 3)
         begin
            wr(8'hC0, 8'hA0, {3'h0, v[15:8]}, v[7:0], 8'h00);
            eeM[v[15:8]] = v[7:0];
         end
         else
         begin
            wr({4'h4, v[19], 3'h0}, {4'h2, v[19], 3'h0}, v[18:8], v[7:0], 8'hFF);
            pgM[v[19:8]] = v[7:0];
         end
      end
      foreach (eeM[a])
      begin
         ins({16'hA000, a[7:0], 8'h00});
         `CHK("ee_model", eeM[a], r[7:0])
      end
      foreach (pgM[a])
      begin
         ins({4'h2, a[11], 3'h0, 5'h0, a[10:0], 8'h00});
         `CHK("pg_model", pgM[a], r[7:0])
      end
      for (int i = 0; i < 2; i++)
      begin
         v = rnd();
         ins({8'hAC, 3'h5, v[4:0], 16'h0000});
         tick(8);
         `CHK("fuse_pins", v[4:0], fuseBits)
         ins(32'h50000000);
         `CHK("fuse_read", {1'b0, v[4:0]}, r[5:0])
      end
      foreach (sig[i])
      begin
         ins({16'h3000, 6'h0, i[1:0], 8'h00});
         `CHK("sig", sig[i], r[7:0])
      end
      ins(32'hACFD0000);
      idle();
      `CHK("lock_pins", 2'h2, lockBits)
      ins(32'h58000000);
      `CHK("lock_read", 2'h2, r[2:1])
      ins(32'hACF90000);
      idle();
      `CHK("lock_pins", 2'h0, lockBits)
      ins(32'h30000100);
      `CHK("sig_locked", 8'h00, r[7:0])
      pin(1'b1);
      `CHK("mode", 1'b0, progMode)
      pin(1'b0);
      ins(32'hC0000155);
      tick(4);
      `CHK("busy", 1'b0, busy)
      finish_test();
   end
endmodule
